/* design/prc_params.svh */
// offsets, field positions, reset values and timing counts
// assumes a 32-bit register bus with byte addressing and a 100 MHz clock
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

// register byte offsets
`define PRC_ADDR_WIDTH 5
`define PRC_ADDR_CTRL 5'h00
`define PRC_ADDR_CFG 5'h04
`define PRC_ADDR_DIV 5'h08
`define PRC_ADDR_N2 5'h0C
`define PRC_ADDR_STATUS 5'h10

// control word
`define PRC_CTRL_TUNE_BIT 0
`define PRC_TUNE_RESET 1'b1

// input configuration word, field least significant bits
`define PRC_CFG_BUF_LSB 0
`define PRC_CFG_MODE_LSB 2
`define PRC_CFG_WIN_LSB 4
`define PRC_CFG_FMT_LSB 6
`define PRC_CFG_FIELD_RESET 2'h0

// divider word
`define PRC_DIV_WIDTH 12
`define PRC_DIV_REF_LSB 0
`define PRC_DIV_FB_LSB 16
`define PRC_DIV_RESET 1
`define PRC_N2_WIDTH 18
`define PRC_N2_RESET 1

// status word bits
`define PRC_ST_LOSS_A 0
`define PRC_ST_LOSS_B 1
`define PRC_ST_SEL_B 2
`define PRC_ST_TUNE_PEND 3
`define PRC_ST_LOCK 4

// loss window: lowest detectable input frequency, in kHz
`define PRC_CLK_KHZ 100000
`define PRC_LOSS_MIN0_KHZ 1000
`define PRC_LOSS_MIN1_KHZ 3000
`define PRC_LOSS_MIN2_KHZ 13000
`define PRC_LOSS_MIN3_KHZ 32000
// one input period in clock cycles, rounded up
`define PRC_LOSS_CYC(f) ((`PRC_CLK_KHZ + (f) - 1) / (f))
`define PRC_LOSS_CNT_WIDTH 8

`endif

/* design/prc_pkg.sv */
// types shared by the reference select block
// assumes nothing beyond a SystemVerilog compiler
package prc_pkg;

  // select field decode, codes follow the field value
  typedef enum logic [1:0] {
    MODE_FORCE_A,
    MODE_FORCE_B,
    MODE_NONREVERT,
    MODE_REVERT
  } prc_mode_e;

  // loss pin drive format, codes follow the field value
  typedef enum logic [1:0] {
    PIN_RESERVED,
    PIN_NMOS_OD,
    PIN_PMOS_OD,
    PIN_CMOS
  } prc_pin_e;

  typedef enum logic {SEL_A, SEL_B} prc_sel_e;
  typedef enum logic {TUNE_IDLE, TUNE_WAIT} prc_tune_e;

endpackage

/* design/prc_loss_detect.sv */
// loss-of-signal detector for one reference input
// assumes refIn is already synchronous to clk
`timescale 1ns/10ps
`include "prc_params.svh"
module prc_loss_detect
  import prc_pkg::*;
#(
  parameter int CNT_WIDTH = `PRC_LOSS_CNT_WIDTH
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic refIn,
  input wire logic [CNT_WIDTH-1:0] windowCycles,
  output logic refEdge,
  output logic lost
);

  // the parked counter needs at least two bits to span a window
  if (CNT_WIDTH < 2 || CNT_WIDTH > 16) begin : g_bad_width
    $error("prc_loss_detect: unsupported counter width");
  end

  logic prevIn;
  logic [CNT_WIDTH-1:0] cnt;
  logic next_prevIn;
  logic [CNT_WIDTH-1:0] next_cnt;
  logic next_lost;

  assign refEdge = refIn & ~prevIn;

  ////////////////////////////////////////////////////////////////////////
  // R16: edge timeout
  // an edge restarts the window; running out of window raises the loss
  always_comb begin
    next_prevIn = refIn;
    next_cnt = cnt;
    next_lost = lost;
    if (refEdge) begin
      next_cnt = '0;
      next_lost = 1'b0;
    end else if (cnt >= windowCycles - CNT_WIDTH'(1)) begin
      next_lost = 1'b1; // counter parks here until edges resume
    end else begin
      next_cnt = cnt + CNT_WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prevIn <= 1'b0;
      cnt <= '0;
      lost <= 1'b0;
    end else begin
      prevIn <= next_prevIn;
      cnt <= next_cnt;
      lost <= next_lost;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks on the timeout
  a_loss_raise: assert property (@(posedge clk) disable iff (!rstN) // R16
    (!refEdge && cnt >= windowCycles - CNT_WIDTH'(1)) |=> lost)
    else $error("loss not raised at end of window");
  a_loss_clear: assert property (@(posedge clk) disable iff (!rstN) // R16
    refEdge |=> (!lost && cnt == '0))
    else $error("loss not cleared by an input edge");

endmodule

/* design/prc_divider.sv */
// programmable divide-by-N pulse counter
// assumes divValue is never zero; the register side rejects zero
`timescale 1ns/10ps
module prc_divider
  import prc_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic tick,
  input wire logic [WIDTH-1:0] divValue,
  output logic pulse
);

  // a counter of no bits cannot divide
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("prc_divider: unsupported counter width");
  end

  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic next_pulse;

  // one pulse per divValue ticks; >= keeps a shrunk ratio from stalling
  always_comb begin
    next_cnt = cnt;
    next_pulse = 1'b0;
    if (tick) begin
      if (cnt >= divValue - WIDTH'(1)) begin
        next_cnt = '0;
        next_pulse = 1'b1;
      end else begin
        next_cnt = cnt + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt <= '0;
      pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pulse <= next_pulse;
    end
  end

endmodule

/* design/prc_ref_select.sv */
// first-loop reference select, loss flags, dividers and tuning gate
// assumes Avalon-MM master on clk; reference and oscillator inputs are
// already synchronous to clk and slower than half the clock rate
//
// Function
// R1: tune bit set: hold second-loop tuning until first-loop lock reported
// R2: tune bit clear: tuning starts right after second-loop divider write
// R3: first loop keeps running its reference path whatever the tune bit
// R4: two buffer kind bits, bit0 input A, bit1 input B; 1 means MOS
// R5: select field 00 force A, 01 force B, 10 non-revertive, 11 revertive
// R6: both automatic modes begin with input A selected
// R7: revertive picks A whenever active, B only while A is lost
// R8: non-revertive switches only when the selected input fails
// R9: per-input loss flags drive switching, shown only in automatic modes
// R10: one shared window field: 1, 3.0, 13 or 32 MHz minimum
// R11: loss pin format 00 reserved, 01 NMOS OD, 10 PMOS OD, 11 CMOS
// R12: host sets pin format 00 while a fixed input is forced
// R13: host starts with forced A, rewrites select after references start
// R14: feedback divider 12 bits, ratio 1 to 4095, zero rejected
// R15: reference divider 12 bits, ratio 1 to 4095, zero rejected
// R16: loss raised after one minimum-frequency period without input edges
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "prc_params.svh"
module prc_ref_select
  import prc_pkg::*;
#(
  parameter int DIV_WIDTH = `PRC_DIV_WIDTH,
  parameter int N2_WIDTH = `PRC_N2_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`PRC_ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic refInputA,
  input wire logic refInputB,
  input wire logic oscillatorInput,
  input wire logic firstLoopLockDetect,
  output logic refALossOut,
  output logic refALossOeN,
  output logic refBLossOut,
  output logic refBLossOeN,
  output logic refABufferMos,
  output logic refBBufferMos,
  output logic selectedRefB,
  output logic refDivPulse,
  output logic fbDivPulse,
  output logic vcoTuneStart,
  output logic [N2_WIDTH-1:0] secondLoopDivider
);

  // refuse widths that the field layout cannot hold
  if (DIV_WIDTH < 2 || DIV_WIDTH > 16 || N2_WIDTH < 1 || N2_WIDTH > 32)
  begin : g_bad_width
    $error("prc_ref_select: unsupported divider width");
  end

  function automatic logic isAutoMode(input logic [1:0] mode);
    return mode[1];
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rstMeta;
  logic rstN;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  ////////////////////////////////////////////////////////////////////////
  // bus slave and register file
  logic tuneAfterRefLock;
  logic [1:0] refInputBufferKind;
  logic [1:0] refSelectMode;
  logic [1:0] lossDetectWindow;
  logic [1:0] lossPinFormat;
  logic [DIV_WIDTH-1:0] firstLoopRefDivider;
  logic [DIV_WIDTH-1:0] firstLoopFeedbackDivider;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic next_tune;
  logic [1:0] next_bufKind;
  logic [1:0] next_selMode;
  logic [1:0] next_window;
  logic [1:0] next_format;
  logic [DIV_WIDTH-1:0] next_refDiv;
  logic [DIV_WIDTH-1:0] next_fbDiv;
  logic [N2_WIDTH-1:0] next_n2Div;
  logic [31:0] regWord;
  logic [31:0] wrWord;
  logic [31:0] statusWord;
  logic wrEn;
  logic divWrite;
  logic cfgWrite;
  logic n2Write;
  logic [1:0] lostRaw;
  prc_sel_e selState;
  prc_tune_e tuneState;

  assign wrEn = avs_write & ~avs_waitrequest;
  assign divWrite = wrEn && avs_address == `PRC_ADDR_DIV;
  assign cfgWrite = wrEn && avs_address == `PRC_ADDR_CFG;
  assign n2Write = wrEn && avs_address == `PRC_ADDR_N2;
  assign refABufferMos = refInputBufferKind[0];
  assign refBBufferMos = refInputBufferKind[1];

  always_comb begin
    statusWord = '0;
    statusWord[`PRC_ST_LOSS_A] = lostRaw[0];
    statusWord[`PRC_ST_LOSS_B] = lostRaw[1];
    statusWord[`PRC_ST_SEL_B] = selState == SEL_B;
    statusWord[`PRC_ST_TUNE_PEND] = tuneState == TUNE_WAIT;
    statusWord[`PRC_ST_LOCK] = firstLoopLockDetect;
  end

  // current word at the address; unmapped reads return zero
  always_comb begin
    regWord = '0;
    case (avs_address)
      `PRC_ADDR_CTRL: regWord[`PRC_CTRL_TUNE_BIT] = tuneAfterRefLock;
      `PRC_ADDR_CFG: begin
        regWord[`PRC_CFG_BUF_LSB +: 2] = refInputBufferKind;
        regWord[`PRC_CFG_MODE_LSB +: 2] = refSelectMode;
        regWord[`PRC_CFG_WIN_LSB +: 2] = lossDetectWindow;
        regWord[`PRC_CFG_FMT_LSB +: 2] = lossPinFormat;
      end
      `PRC_ADDR_DIV: begin
        regWord[`PRC_DIV_REF_LSB +: DIV_WIDTH] = firstLoopRefDivider;
        regWord[`PRC_DIV_FB_LSB +: DIV_WIDTH] = firstLoopFeedbackDivider;
      end
      `PRC_ADDR_N2: regWord[N2_WIDTH-1:0] = secondLoopDivider;
      `PRC_ADDR_STATUS: regWord = statusWord;
      default: regWord = '0;
    endcase
    wrWord = mergeBytes(regWord, avs_writedata, avs_byteenable);
  end

  // one wait state: a request is answered on its second cycle
  always_comb begin
    next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
    next_readdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      next_readdata = regWord;
    end
    next_tune = tuneAfterRefLock;
    next_bufKind = refInputBufferKind;
    next_selMode = refSelectMode;
    next_window = lossDetectWindow;
    next_format = lossPinFormat;
    next_refDiv = firstLoopRefDivider;
    next_fbDiv = firstLoopFeedbackDivider;
    next_n2Div = secondLoopDivider;
    if (wrEn && avs_address == `PRC_ADDR_CTRL) begin
      next_tune = wrWord[`PRC_CTRL_TUNE_BIT];
    end
    // R4, R5, R10, R11: buffer kind, select, window and pin format fields
    if (cfgWrite) begin
      next_bufKind = wrWord[`PRC_CFG_BUF_LSB +: 2];
      next_selMode = wrWord[`PRC_CFG_MODE_LSB +: 2];
      next_window = wrWord[`PRC_CFG_WIN_LSB +: 2];
      next_format = wrWord[`PRC_CFG_FMT_LSB +: 2];
    end
    // R15: reference ratio, zero kept out
    if (divWrite && wrWord[`PRC_DIV_REF_LSB +: DIV_WIDTH] != '0) begin
      next_refDiv = wrWord[`PRC_DIV_REF_LSB +: DIV_WIDTH];
    end
    // R14: feedback ratio, zero kept out
    if (divWrite && wrWord[`PRC_DIV_FB_LSB +: DIV_WIDTH] != '0) begin
      next_fbDiv = wrWord[`PRC_DIV_FB_LSB +: DIV_WIDTH];
    end
    if (n2Write) begin
      next_n2Div = wrWord[N2_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      tuneAfterRefLock <= `PRC_TUNE_RESET;
      refInputBufferKind <= `PRC_CFG_FIELD_RESET;
      refSelectMode <= `PRC_CFG_FIELD_RESET;
      lossDetectWindow <= `PRC_CFG_FIELD_RESET;
      lossPinFormat <= `PRC_CFG_FIELD_RESET;
      firstLoopRefDivider <= DIV_WIDTH'(`PRC_DIV_RESET);
      firstLoopFeedbackDivider <= DIV_WIDTH'(`PRC_DIV_RESET);
      secondLoopDivider <= N2_WIDTH'(`PRC_N2_RESET);
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      tuneAfterRefLock <= next_tune;
      refInputBufferKind <= next_bufKind;
      refSelectMode <= next_selMode;
      lossDetectWindow <= next_window;
      lossPinFormat <= next_format;
      firstLoopRefDivider <= next_refDiv;
      firstLoopFeedbackDivider <= next_fbDiv;
      secondLoopDivider <= next_n2Div;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loss detection on both inputs
  logic [1:0] refIn;
  logic [1:0] refEdge;
  logic [`PRC_LOSS_CNT_WIDTH-1:0] windowCycles;

  assign refIn = {refInputB, refInputA};

  // R10: shared window decode
  always_comb begin
    unique case (lossDetectWindow)
      2'h0: windowCycles = 8'(`PRC_LOSS_CYC(`PRC_LOSS_MIN0_KHZ));
      2'h1: windowCycles = 8'(`PRC_LOSS_CYC(`PRC_LOSS_MIN1_KHZ));
      2'h2: windowCycles = 8'(`PRC_LOSS_CYC(`PRC_LOSS_MIN2_KHZ));
      2'h3: windowCycles = 8'(`PRC_LOSS_CYC(`PRC_LOSS_MIN3_KHZ));
    endcase
  end

  for (genvar i = 0; i < 2; i++) begin : g_loss
    prc_loss_detect #(
      .CNT_WIDTH(`PRC_LOSS_CNT_WIDTH)
    ) u_detect (
      .clk(clk),
      .rstN(rstN),
      .refIn(refIn[i]),
      .windowCycles(windowCycles),
      .refEdge(refEdge[i]),
      .lost(lostRaw[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // loss pins; detectors run always but flags show only in auto modes
  logic [1:0] pinOut;
  logic [1:0] pinOeN;
  logic [1:0] next_pinOut;
  logic [1:0] next_pinOeN;
  logic [1:0] flagShown;

  // R9: flags gated by mode
  assign flagShown = isAutoMode(refSelectMode) ? lostRaw : 2'h0;

  // R11: pin format, flag active high on the wire
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      next_pinOut[p] = 1'b0;
      next_pinOeN[p] = 1'b1;
      unique case (prc_pin_e'(lossPinFormat))
        PIN_RESERVED: next_pinOeN[p] = 1'b1;
        PIN_NMOS_OD: next_pinOeN[p] = flagShown[p];
        PIN_PMOS_OD: begin
          next_pinOut[p] = 1'b1;
          next_pinOeN[p] = ~flagShown[p];
        end
        PIN_CMOS: begin
          next_pinOut[p] = flagShown[p];
          next_pinOeN[p] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinOut <= 2'h0;
      pinOeN <= 2'h3;
    end else begin
      pinOut <= next_pinOut;
      pinOeN <= next_pinOeN;
    end
  end

  assign refALossOut = pinOut[0];
  assign refALossOeN = pinOeN[0];
  assign refBLossOut = pinOut[1];
  assign refBLossOeN = pinOeN[1];

  ////////////////////////////////////////////////////////////////////////
  // reference selection
  logic prevAuto;
  logic next_prevAuto;
  prc_sel_e next_sel;

  // R5: select decode
  always_comb begin
    next_sel = selState;
    next_prevAuto = isAutoMode(refSelectMode);
    unique case (prc_mode_e'(refSelectMode))
      MODE_FORCE_A: next_sel = SEL_A;
      MODE_FORCE_B: next_sel = SEL_B;
      // R6: automatic entry on A
      // R8: switch only on failure of the selected input
      MODE_NONREVERT: begin
        if (!prevAuto) begin
          next_sel = SEL_A;
        end else if (selState == SEL_A && lostRaw[0] && !lostRaw[1]) begin
          next_sel = SEL_B;
        end else if (selState == SEL_B && lostRaw[1] && !lostRaw[0]) begin
          next_sel = SEL_A;
        end
      end
      // R7: A preferred whenever present
      MODE_REVERT: begin
        if (prevAuto && lostRaw[0] && !lostRaw[1]) begin
          next_sel = SEL_B;
        end else begin
          next_sel = SEL_A;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      selState <= SEL_A;
      prevAuto <= 1'b0;
    end else begin
      selState <= next_sel;
      prevAuto <= next_prevAuto;
    end
  end

  assign selectedRefB = selState == SEL_B;

  ////////////////////////////////////////////////////////////////////////
  // first-loop dividers feeding the phase detector
  logic selTick;
  logic oscPrev;
  logic oscEdge;

  // R3: reference path never waits on the tune bit
  assign selTick = selState == SEL_B ? refEdge[1] : refEdge[0];
  assign oscEdge = oscillatorInput & ~oscPrev;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      oscPrev <= 1'b0;
    end else begin
      oscPrev <= oscillatorInput;
    end
  end

  prc_divider #(.WIDTH(DIV_WIDTH)) u_ref_div (
    .clk(clk),
    .rstN(rstN),
    .tick(selTick),
    .divValue(firstLoopRefDivider),
    .pulse(refDivPulse)
  );

  prc_divider #(.WIDTH(DIV_WIDTH)) u_fb_div (
    .clk(clk),
    .rstN(rstN),
    .tick(oscEdge),
    .divValue(firstLoopFeedbackDivider),
    .pulse(fbDivPulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // second-loop tuning gate; a fresh divider write restarts the wait
  prc_tune_e next_tuneState;
  logic next_tuneStart;

  always_comb begin
    next_tuneState = tuneState;
    next_tuneStart = 1'b0;
    unique case (tuneState)
      TUNE_IDLE: begin
        if (n2Write) begin
          next_tuneState = TUNE_WAIT;
        end
      end
      // R1: hold for lock
      // R2: no hold with tune bit clear
      TUNE_WAIT: begin
        if (n2Write) begin
          next_tuneState = TUNE_WAIT;
        end else if (!tuneAfterRefLock || firstLoopLockDetect) begin
          next_tuneState = TUNE_IDLE;
          next_tuneStart = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tuneState <= TUNE_IDLE;
      vcoTuneStart <= 1'b0;
    end else begin
      tuneState <= next_tuneState;
      vcoTuneStart <= next_tuneStart;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_n2_write_free;
    n2Write && !tuneAfterRefLock;
  endsequence
  sequence s_tune_fires;
    ##2 vcoTuneStart;
  endsequence

  a_tune_hold: assert property ( // R1
    (tuneState == TUNE_WAIT && tuneAfterRefLock && !firstLoopLockDetect)
    |=> !vcoTuneStart)
    else $error("tuning started before first-loop lock");
  a_tune_now: assert property (s_n2_write_free |-> s_tune_fires) // R2
    else $error("tuning not started after divider write");
  a_ref_path: assert property ( // R3
    (selTick && firstLoopRefDivider == DIV_WIDTH'(1)) |=> refDivPulse)
    else $error("reference divider stalled");
  a_buf_kind: assert property ( // R4
    (cfgWrite && avs_byteenable[0]) |=>
    (refABufferMos == $past(avs_writedata[0]) &&
     refBBufferMos == $past(avs_writedata[1])))
    else $error("buffer kind bits not taken");
  a_force_b: assert property (refSelectMode == 2'h1 |=> selectedRefB) // R5
    else $error("forced input B not selected");
  a_auto_start: assert property ( // R6
    (isAutoMode(refSelectMode) && !prevAuto) |=> !selectedRefB)
    else $error("automatic mode did not begin on input A");
  a_revert_a: assert property ( // R7
    (refSelectMode == 2'h3 && prevAuto && !lostRaw[0]) |=> !selectedRefB)
    else $error("revertive mode left input A while present");
  a_nonrevert_keep: assert property ( // R8
    (refSelectMode == 2'h2 && prevAuto && selState == SEL_B && !lostRaw[1])
    |=> selectedRefB)
    else $error("non-revertive mode left a good input");
  a_flag_forced: assert property ( // R9
    (!isAutoMode(refSelectMode) && lossPinFormat == 2'h3)
    |=> (!refALossOut && !refBLossOut && !refALossOeN))
    else $error("loss flag shown in a forced mode");
  a_pin_reserved: assert property ( // R11
    lossPinFormat == 2'h0 |=> (refALossOeN && refBLossOeN))
    else $error("loss pin driven in reserved format");
  a_fb_zero: assert property ( // R14
    (divWrite && wrWord[`PRC_DIV_FB_LSB +: DIV_WIDTH] == '0)
    |=> $stable(firstLoopFeedbackDivider))
    else $error("zero feedback ratio accepted");

endmodule

/* testbench/prc_ref_source.sv */
// two reference clock sources and the oscillator for the select block
// assumes one shared 100 MHz clk; sources are synchronous to it
`timescale 1ns/10ps
module prc_ref_source (
  input wire logic clk,
  input wire logic runA,
  input wire logic runB,
  output logic refA,
  output logic refB,
  output logic osc
);
  logic [1:0] phase = 2'h0;
  ////////////////////////////////////////////////////////////////////////
  // quarter-rate clocks; a stopped source rests low like a dead input
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    refA <= runA & phase[1];
    refB <= runB & phase[1];
    osc <= phase[1];
  end
endmodule

/* testbench/pll1_reference_select_control_tb.sv */
// self-checking bench for the reference select block
// assumes prc_params.svh on the include path and the source model
`timescale 1ns/10ps
`include "prc_params.svh"
module pll1_reference_select_control_tb;
  logic clk = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0, lock = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic wreq, refA, refB, osc, runA = 1'b1, runB = 1'b1;
  logic aOut, aOeN, bOut, bOeN, aMos, bMos, selB, rPul, fPul, tune;
  logic [17:0] n2;
  int errors = 0, nCompared = 0, rCnt = 0, fCnt = 0, tCnt = 0;
  prc_ref_select dut (.clk(clk), .reset_n(reset_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .refInputA(refA), .refInputB(refB), .oscillatorInput(osc),
    .firstLoopLockDetect(lock), .refALossOut(aOut), .refALossOeN(aOeN),
    .refBLossOut(bOut), .refBLossOeN(bOeN), .refABufferMos(aMos),
    .refBBufferMos(bMos), .selectedRefB(selB), .refDivPulse(rPul),
    .fbDivPulse(fPul), .vcoTuneStart(tune), .secondLoopDivider(n2));
  prc_ref_source src (.clk(clk), .runA(runA), .runB(runB), .refA(refA),
    .refB(refB), .osc(osc));
  ////////////////////////////////////////////////////////////////////////
  // clock and pulse tallies, sampled at the edge
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    rCnt += int'(rPul === 1'b1);
    fCnt += int'(fPul === 1'b1);
    tCnt += int'(tune === 1'b1);
  end
  task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one access; a spare edge after release keeps drives one per step
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic put(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic get(input string nm, input logic [4:0] a,
      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, e, q);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    get("ctrl", `PRC_ADDR_CTRL, 32'h1);
    get("cfg", `PRC_ADDR_CFG, 32'h0);
    get("div", `PRC_ADDR_DIV, 32'h00010001);
    get("unmapped", 5'h14, 32'h0);
    check("selB", 32'h0, selB);
  endtask
  task automatic t_buffer();
    for (int i = 0; i < 4; i++) begin
      put(`PRC_ADDR_CFG, i);
      cyc(2);
      check("bufKind", i, {bMos, aMos});
    end
    put(`PRC_ADDR_CFG, 32'h04);
    cyc(3);
    check("forceB", 32'h1, selB);
    check("aOeN", 32'h1, aOeN);
    put(`PRC_ADDR_CFG, 32'h00);
    cyc(3);
    check("forceA", 32'h0, selB);
  endtask
  task automatic t_revert();
    logic [31:0] q;
    // host starts forced on A, then rewrites the select and pin format fields
    // revertive start on A
    put(`PRC_ADDR_CFG, 32'hCC);
    cyc(3);
    check("revStart", 32'h0, selB);
    runA <= 1'b0;
    cyc(60);
    check("winHold", 32'h0, selB);
    cyc(70);
    check("revB", 32'h1, selB);
    check("cmosPin", 32'h1, {aOeN, aOut});
    bus(1'b0, `PRC_ADDR_STATUS, 32'h0, q);
    check("status", 32'h5, q[2:0]);
    // pin format left set in forced mode on purpose: the flag must hide
    put(`PRC_ADDR_CFG, 32'hC0);
    cyc(2);
    check("flagHidden", 32'h0, {aOeN, aOut});
    put(`PRC_ADDR_CFG, 32'hCC);
    cyc(3);
    check("revReturn", 32'h1, selB);
    runA <= 1'b1;
    cyc(20);
    check("revBack", 32'h0, selB);
    check("cmosClr", 32'h0, aOut);
    // open-drain high format while the window narrows
    for (int c = 1; c < 4; c++) begin
      put(`PRC_ADDR_CFG, 32'h8C | (c << 4));
      cyc(20);
      check("winRun", 32'h0, selB);
      check("pmosIdle", 32'h3, {aOeN, aOut});
      runA <= 1'b0;
      cyc(c == 1 ? 45 : 18);
      check("winLoss", 32'h1, selB);
      check("pmosLoss", 32'h1, {aOeN, aOut});
      runA <= 1'b1;
    end
  endtask
  task automatic t_nonrev();
    put(`PRC_ADDR_CFG, 32'h00);
    put(`PRC_ADDR_CFG, 32'h48);
    cyc(20);
    check("nrStart", 32'h0, selB);
    check("nmosIdle", 32'h0, {aOeN, aOut});
    runA <= 1'b0;
    cyc(130);
    check("nrB", 32'h1, selB);
    check("nmosRel", 32'h1, aOeN);
    runA <= 1'b1;
    cyc(20);
    check("nrKeep", 32'h1, selB);
    runB <= 1'b0;
    cyc(130);
    check("nrA", 32'h0, selB);
    check("nmosRelB", 32'h2, {bOeN, bOut});
    runB <= 1'b1;
  endtask
  task automatic t_tune();
    int t0;
    put(`PRC_ADDR_CTRL, 32'h0);
    t0 = tCnt;
    put(`PRC_ADDR_N2, 32'h5);
    cyc(4);
    check("tuneNow", 32'h1, tCnt - t0);
    put(`PRC_ADDR_CTRL, 32'h1);
    t0 = tCnt;
    put(`PRC_ADDR_N2, 32'h7);
    cyc(20);
    check("tuneHeld", 32'h0, tCnt - t0);
    lock <= 1'b1;
    cyc(4);
    check("tuneLock", 32'h1, tCnt - t0);
    check("n2", 32'h7, n2);
    lock <= 1'b0;
    put(`PRC_ADDR_CTRL, 32'h0);
  endtask
  task automatic t_div();
    put(`PRC_ADDR_DIV, 32'h00020003);
    put(`PRC_ADDR_DIV, 32'h0);
    get("divZero", `PRC_ADDR_DIV, 32'h00020003);
    put(`PRC_ADDR_DIV, 32'h00000005);
    get("divField", `PRC_ADDR_DIV, 32'h00020005);
    rCnt = 0;
    fCnt = 0;
    cyc(400);
    check("refPulses", 32'h1, rCnt >= 19 && rCnt <= 21);
    check("fbPulses", 32'h1, fCnt >= 49 && fCnt <= 51);
    put(`PRC_ADDR_DIV, 32'hFFFFFFFF);
    get("divMax", `PRC_ADDR_DIV, 32'h0FFF0FFF);
  endtask
  task automatic report_and_stop();
    if (errors == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence, then a watchdog far beyond its roughly 1100 cycles
  initial begin
    cyc(20);
    reset_n <= 1'b1;
    cyc(4);
    t_reset();
    t_buffer();
    t_revert();
    t_nonrev();
    t_tune();
    t_div();
    report_and_stop();
  end
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule
